// ---- logic/adcc_conv.sv ----
`timescale 1ns/1ns
// internal conversion controller: times the conversion, formats the result
module adcc_conv #(
  parameter int unsigned CONV_LEN = adcc_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // hand-off from the serial side
  input wire logic start_i,
  input wire adcc_pkg::adcc_cfg_s cfg_i,
  // raw code from the approximation array
  input wire logic [adcc_pkg::RES_W-1:0] raw_i,
  // status and formatted result
  output logic busy_o,
  output logic [adcc_pkg::WORD_W-1:0] word_o
);
  import adcc_pkg::*;

  adcc_state_e state_q;
  adcc_state_e state_d;
  logic [CONV_CNT_W-1:0] cnt_q;
  logic [CONV_CNT_W-1:0] cnt_d;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] word_d;
  adcc_cfg_s cfg_q;
  adcc_cfg_s cfg_d;
  logic [RES_W-1:0] res;

  // bit reversal for lsb-first output
  function automatic logic [RES_W-1:0] rev(input logic [RES_W-1:0] v);
    logic [RES_W-1:0] r;
    r = '0;
    for (int i = 0; i < RES_W; i++) begin
      r[i] = v[RES_W-1-i];
    end
    return r;
  endfunction

  // bipolar is offset binary relative to mid-scale, so flip the top bit
  always_comb begin
    res = raw_i;
    if (cfg_q.bipolar) begin
      res[RES_W-1] = ~raw_i[RES_W-1];
    end
  end

  // R14 bounded conversion time
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    word_d = word_q;
    cfg_d = cfg_q;
    case (state_q)
      ADCC_IDLE: begin
        if (start_i) begin
          cfg_d = cfg_i;
          cnt_d = '0;
          state_d = ADCC_CONV;
        end
      end
      ADCC_CONV: begin
        cnt_d = cnt_q + 1'b1;
        // R12 result ready at end
        if (cnt_q == CONV_CNT_W'(CONV_LEN - 1)) begin
          word_d = cfg_q.lsb_first ? {rev(res), PAD_ZERO} : {res, PAD_ZERO};
          state_d = ADCC_IDLE;
        end
      end
      default: state_d = ADCC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ADCC_IDLE;
      cnt_q <= '0;
      word_q <= WORD_RST;
      cfg_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      cfg_q <= cfg_d;
    end
  end

  assign busy_o = (state_q == ADCC_CONV);
  assign word_o = word_q;

endmodule

// ---- logic/adcc_pkg.sv ----
package adcc_pkg;

  // result and command widths
  localparam int unsigned RES_W = 12;
  localparam int unsigned CMD_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 5;

  // frame positions, counted in shift-clock edges
  localparam logic [CNT_W-1:0] ADDR_LAST_RISE = 5'h03;
  localparam logic [CNT_W-1:0] CMD_RISES = 5'h08;
  localparam logic [CNT_W-1:0] SAMPLE_FALL = 5'h03;

  // output length codes in the command and their frame lengths
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h3;
  localparam logic [CNT_W-1:0] FRAME_8 = 5'h08;
  localparam logic [CNT_W-1:0] FRAME_12 = 5'h0C;
  localparam logic [CNT_W-1:0] FRAME_16 = 5'h10;

  // channel code that powers the converter down instead of converting
  localparam logic [ADDR_W-1:0] PWRDN_ADDR = 4'hE;

  // reset values and result padding
  localparam logic [CMD_W-1:0] CMD_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [3:0] PAD_ZERO = 4'h0;

  // conversion time
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CONV_TIME_NS = 10000;
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CNT_W = 11;

  // configuration half of the command byte
  typedef struct packed {
    logic [1:0] len;
    logic lsb_first;
    logic bipolar;
  } adcc_cfg_s;

  // whole command byte as shifted in
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    adcc_cfg_s cfg;
  } adcc_cmd_s;

  // conversion controller states
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_e;

  // frame length from the length code
  function automatic logic [CNT_W-1:0] adcc_frame_len(input logic [1:0] len);
    if (len == LEN_8) begin
      return FRAME_8;
    end else if (len == LEN_16) begin
      return FRAME_16;
    end else begin
      return FRAME_12;
    end
  endfunction

endpackage

// ---- logic/adcc_sync.sv ----
`timescale 1ns/1ns
// two-stage synchroniser for a level from another domain
module adcc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // level in and out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  import adcc_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second
  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule

// ---- logic/adcc_top.sv ----
`timescale 1ns/1ns
// Summary of operation
// R1 - select falling resets frame counters and enables data, shift clock, output
// R2 - select rising stops taking command bits and shift clock
// R3 - four address bits, msb first, on the first four rising edges
// R4 - eight command bits on first eight rising edges, address after fourth
// R5 - result output floats while select high, driven while low
// R6 - first result bit appears as soon as select goes low
// R7 - each falling shift edge advances the result output one bit
// R8 - remaining result bits follow on successive shift clocks
// R9 - sampling runs from fourth falling edge to the frame's last falling edge
// R10 - last falling edge hands the conversion to the internal controller
// R11 - conversion-done drops after last falling edge, low until result ready
// R12 - conversion-done rises at the end of every conversion
// R13 - channel address picks one of fourteen multiplexer sources
// R14 - each conversion completes within ten microseconds
// R15 - host waits the select setup time before the first address bit
// R16 - low four command bits set length, bit order, format, power-down; code takes power-down from channel address 4'hE instead
module adcc_top #(
  parameter int unsigned CONV_LEN = adcc_pkg::CONV_CYCLES
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial link from the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic eoc_o,
  // analog front end
  input wire logic [adcc_pkg::RES_W-1:0] raw_i,
  output logic [adcc_pkg::ADDR_W-1:0] mux_addr_o,
  output logic sample_o,
  output logic pwrdn_o
);
  import adcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link domain, rising shift edges

  logic [CNT_W-1:0] rise_cnt_q;
  logic [CNT_W-1:0] rise_cnt_d;
  logic [CMD_W-1:0] shift_q;
  logic [CMD_W-1:0] shift_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  adcc_cfg_s cfg_q;
  adcc_cfg_s cfg_d;

  // R3 address shift
  always_comb begin
    rise_cnt_d = rise_cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    cfg_d = cfg_q;
    // R4 eight command bits
    if (rise_cnt_q < CMD_RISES) begin
      rise_cnt_d = rise_cnt_q + 1'b1;
      shift_d = {shift_q[CMD_W-2:0], din_i};
    end
    // R13 channel select
    if (rise_cnt_q == ADDR_LAST_RISE) begin
      addr_d = {shift_q[ADDR_W-2:0], din_i};
    end
    // R16 configuration bits
    if (rise_cnt_q == CMD_RISES - 1'b1) begin
      cfg_d = adcc_cfg_s'({shift_q[2:0], din_i});
    end
  end

  // R1 counters cleared while select is high, R2 no edges taken then
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rise_cnt_q <= '0;
      shift_q <= CMD_RST;
    end else begin
      rise_cnt_q <= rise_cnt_d;
      shift_q <= shift_d;
    end
  end

  // address and configuration outlive the frame for the conversion;
  // while deselected the rise count sits at zero, so the next values hold
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_q <= '0;
      cfg_q <= '0;
    end else begin
      addr_q <= addr_d;
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain, falling shift edges

  logic [CNT_W-1:0] fall_cnt_q;
  logic [CNT_W-1:0] fall_cnt_d;
  logic sample_q;
  logic sample_d;
  logic handoff_tgl_q;
  logic handoff_tgl_d;
  logic [CNT_W-1:0] frame_len;
  logic last_fall;

  // length applies once the command is in, half a shift clock or more before the last edge
  assign frame_len = adcc_frame_len(cfg_q.len);
  assign last_fall = (fall_cnt_q == frame_len - 1'b1);

  always_comb begin
    fall_cnt_d = fall_cnt_q;
    sample_d = sample_q;
    // R7 advance one bit
    if (fall_cnt_q < frame_len) begin
      fall_cnt_d = fall_cnt_q + 1'b1;
    end
    // R9 sampling window
    if (fall_cnt_q == SAMPLE_FALL) begin
      sample_d = 1'b1;
    end
    if (last_fall) begin
      sample_d = 1'b0;
    end
  end

  // R1 frame state cleared by select high
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fall_cnt_q <= '0;
      sample_q <= 1'b0;
    end else begin
      fall_cnt_q <= fall_cnt_d;
      sample_q <= sample_d;
    end
  end

  // R10 hand-off toggle
  always_comb begin
    handoff_tgl_d = handoff_tgl_q;
    if (last_fall) begin
      handoff_tgl_d = ~handoff_tgl_q;
    end
  end

  // toggle must survive select rising, so only system reset clears it;
  // a zero fall count never matches the last fall, so it holds while idle
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      handoff_tgl_q <= 1'b0;
    end else begin
      handoff_tgl_q <= handoff_tgl_d;
    end
  end

  assign sample_o = sample_q;
  assign mux_addr_o = addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: hand-off crossing and conversion

  logic handoff_sync;
  logic handoff_seen_q;
  logic handoff_seen_d;
  logic start;
  logic busy;
  logic [WORD_W-1:0] word;
  logic pwrdn_q;
  logic pwrdn_d;

  adcc_sync #(
    .WIDTH(1)
  ) u_handoff_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(handoff_tgl_q),
    .q_o(handoff_sync)
  );

  // address and cfg were stable since the eighth rising edge, so sampled direct
  always_comb begin
    handoff_seen_d = handoff_sync;
    pwrdn_d = pwrdn_q;
    if (handoff_sync != handoff_seen_q) begin
      pwrdn_d = (addr_q == PWRDN_ADDR);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      handoff_seen_q <= 1'b0;
      pwrdn_q <= 1'b0;
    end else begin
      handoff_seen_q <= handoff_seen_d;
      pwrdn_q <= pwrdn_d;
    end
  end

  // R10 controller takes over
  assign start = (handoff_sync != handoff_seen_q) && (addr_q != PWRDN_ADDR);

  adcc_conv #(
    .CONV_LEN(CONV_LEN)
  ) u_conv (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start),
    .cfg_i(cfg_q),
    .raw_i(raw_i),
    .busy_o(busy),
    .word_o(word)
  );

  // R11 low while converting, R12 high again at the end
  assign eoc_o = ~(busy | start);
  assign pwrdn_o = pwrdn_q;

  ////////////////////////////////////////////////////////////////////////////
  // result output

  // R5 drive only while selected
  assign dout_oe_o = ~cs_n_i;
  // R6 first bit with no edge, R8 the rest follow from the count
  assign dout_o = (!cs_n_i && fall_cnt_q < FRAME_16) ?
                  word[WORD_W-1-fall_cnt_q[3:0]] : 1'b0;

endmodule

// ---- tb/adcc_checker.sv ----
`timescale 1ns/1ns
module adcc_checker #(
  parameter int unsigned CONV_LEN = 20
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  // serial link
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic eoc_o,
  // front end
  input wire logic [adcc_pkg::RES_W-1:0] raw_i,
  input wire logic [adcc_pkg::ADDR_W-1:0] mux_addr_o,
  input wire logic sample_o,
  input wire logic pwrdn_o
);
  logic [4:0] fall_q, fall_d, rise_q, rise_d;
  logic [3:0] sh_q, sh_d;
  logic [11:0] low_q, low_d;
  ////////////////////////////////////////
  // edge counts per frame, cleared while deselected
  always_comb begin
    fall_d = fall_q + 5'h01;
    rise_d = rise_q + 5'h01;
    sh_d = {sh_q[2:0], din_i};
    low_d = eoc_o ? 12'h000 : low_q + 12'h001;
  end
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) fall_q <= 5'h00;
    else fall_q <= fall_d;
  end
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rise_q <= 5'h00;
      sh_q <= 4'h0;
    end else begin
      rise_q <= rise_d;
      sh_q <= sh_d;
    end
  end
  // length of the busy span, in system clocks
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) low_q <= 12'h000;
    else low_q <= low_d;
  end
  sequence s_conv_start;
    $fell(eoc_o);
  endsequence
  ////////////////////////////////////////
  // enable follows select
  a_oe_tracks_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dout_oe_o == !cs_n_i) else $error("drive enable wrong");
  a_dout_idle_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n_i |-> !dout_o) else $error("result line active while idle");
  a_dout_fall_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!cs_n_i && !$past(cs_n_i) && !$fell(sclk_i)) |-> $stable(dout_o))
    else $error("result bit moved without a fall");
  a_sample_open: assert property (@(posedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    fall_q == 5'h04 |-> sample_o) else $error("sampling not open");
  a_sample_early: assert property (@(posedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    fall_q < 5'h04 |-> !sample_o) else $error("sampling too early");
  // window shut by the time the conversion starts
  a_sample_closed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_conv_start |-> !sample_o) else $error("sampling still open");
  a_addr_ready: assert property (@(negedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    rise_q == 5'h04 |-> mux_addr_o == sh_q) else $error("channel address wrong");
  a_eoc_low_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_conv_start |=> (!eoc_o) [*8]) else $error("done rose too soon");
  a_eoc_bounded: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    low_q <= CONV_LEN + 4) else $error("conversion too long");
  a_eoc_reset: assert property (@(posedge clk_i)
    !rst_n_i |=> eoc_o) else $error("done low after reset");
endmodule
bind adcc_top adcc_checker #(.CONV_LEN(CONV_LEN)) u_adcc_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i),
  .dout_o(dout_o), .dout_oe_o(dout_oe_o), .eoc_o(eoc_o), .raw_i(raw_i),
  .mux_addr_o(mux_addr_o), .sample_o(sample_o), .pwrdn_o(pwrdn_o));

// ---- tb/adcc_host.sv ----
`timescale 1ns/1ns
module adcc_host (
  // serial link toward the converter
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  // shift clock idles low, stopped between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b1;
  end
  ////////////////////////////////////////
  // one frame: command out msb first, bits taken just before each fall
  task automatic frame(input logic [7:0] cmd, input int n, output logic [15:0] got);
    got = 16'h0000;
    #3 cs_n_o = 1'b0;
    #1427;
    for (int i = 0; i < n; i++) begin
      din_o = (i < 8) ? cmd[7-i] : ~din_o;
      #16 sclk_o = 1'b1;
      #15 got = {got[14:0], dout_i};
      #1 sclk_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
    din_o = ~din_o; // released line never holds its last bit
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import adcc_pkg::*;
  localparam int unsigned CONV = 20;
  logic clk_i, rst_n_i, sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, eoc_o, sample_o, pwrdn_o;
  logic [RES_W-1:0] raw_i;
  logic [ADDR_W-1:0] mux_addr_o;
  wire dout_line;
  int fail_count, num_checks;
  // floating line reads as unknown, so a wrong enable shows up
  assign dout_line = dout_oe_o ? dout_o : 1'bz;
  adcc_top #(.CONV_LEN(CONV)) u_adcc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .eoc_o(eoc_o),
    .raw_i(raw_i), .mux_addr_o(mux_addr_o), .sample_o(sample_o), .pwrdn_o(pwrdn_o));
  adcc_host u_adcc_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_line));
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_eoc(input logic lvl, input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge clk_i);
      hit = (eoc_o === lvl);
    end
  endtask
  // one frame, then the busy span of its conversion
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [15:0] exp,
      input logic [11:0] rawv, input logic conv);
    logic [15:0] got;
    logic hit;
    @(negedge clk_i);
    raw_i = rawv;
    u_adcc_host.frame(cmd, n, got);
    check("result bits", got, exp);
    check("channel", {12'h000, mux_addr_o}, {12'h000, cmd[7:4]});
    wait_eoc(1'b0, 10, hit);
    check("done low", {15'h0000, hit}, {15'h0000, conv});
    wait_eoc(1'b1, CONV + 10, hit);
    check("done high", {15'h0000, hit}, 16'h0001);
  endtask
  ////////////////////////////////////////
  task automatic t_idle();
    check("enable idle", {15'h0000, dout_oe_o}, 16'h0000);
    check("done idle", {15'h0000, eoc_o}, 16'h0001);
    $display("idle test done");
  endtask
  task automatic t_first();
    xfer(8'h50, 12, 16'h0000, 12'hA5C, 1'b1);
    $display("first frame test done");
  endtask
  // long frame shows the pad bits after the result
  task automatic t_lengths();
    xfer(8'h3C, 16, 16'hA5C0, 12'h3C1, 1'b1);
    xfer(8'h72, 12, 16'h03C1, 12'h812, 1'b1);
    $display("length test done");
  endtask
  task automatic t_lsb_short();
    xfer(8'h25, 8, 16'h0048, 12'h8F3, 1'b1);
    $display("lsb first test done");
  endtask
  // shutdown channel reads the bipolar result and starts nothing
  task automatic t_pwrdn();
    xfer(8'hE0, 12, 16'h00F3, 12'h000, 1'b0);
    check("power down", {15'h0000, pwrdn_o}, 16'h0001);
    $display("power down test done");
  endtask
  initial begin
    rst_n_i = 1'b0;
    raw_i = 12'h000;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_idle();
    t_first();
    t_lengths();
    t_lsb_short();
    t_pwrdn();
    end_sim();
  end
  // five frames take about 10 us
  initial begin
    #60000;
    fail_count++;
    $display("[ERR] watchdog expected done seen hang");
    end_sim();
  end
endmodule
